// ===== src/nfw_cfg.svh
// Offsets, field positions, reset values and timing figures of the wake-up block.
`ifndef NFW_CFG_SVH
`define NFW_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define NFW_OFS_MOD_CLK 5'h09
`define NFW_OFS_REG_IO 5'h0b
`define NFW_OFS_TWL 5'h18
`define NFW_OFS_TPROT 5'h19

// ----------------------------------------------------------------------------
// Direct command codes and command byte layout
// ----------------------------------------------------------------------------
`define NFW_DC_IDLE 5'h00
`define NFW_DC_SOFT_INIT 5'h03
`define NFW_DC_FIFO_RST 5'h0f
`define NFW_HDR_CMD_BIT 7
`define NFW_HDR_READ_BIT 6

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define NFW_TPROT_WAKE_BIT 7
`define NFW_RST_MOD_CLK 8'h00
`define NFW_RST_REG_IO 8'h00
`define NFW_RST_TWL 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define NFW_CLK_MHZ 50
`define NFW_SOFT_RST_WAIT_US 1000

// ----------------------------------------------------------------------------
// Wake thresholds in mV, normal range then extended range, codes 1 to 7
// ----------------------------------------------------------------------------
`define NFW_THR_N1 11'd480
`define NFW_THR_N2 11'd350
`define NFW_THR_N3 11'd250
`define NFW_THR_N4 11'd220
`define NFW_THR_N5 11'd190
`define NFW_THR_N6 11'd180
`define NFW_THR_N7 11'd170
`define NFW_THR_E1 11'd1500
`define NFW_THR_E2 11'd700
`define NFW_THR_E3 11'd500
`define NFW_THR_E4 11'd450
`define NFW_THR_E5 11'd400
`define NFW_THR_E6 11'd320
`define NFW_THR_E7 11'd280

`endif

// ===== src/nfw_pkg.sv
// Types shared by the wake-up block modules.
package nfw_pkg;

	// Target wake level register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic ident_size_hi;
		logic ident_size_lo;
		logic sdd_en;
		logic unused4;
		logic extended_range_select;
		logic [2:0] wake_threshold;
	} nfw_twl_t;

	// One register access taken from the command port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] data;
	} nfw_acc_t;

	typedef enum logic [0:0] {
		NFW_CP_HDR,
		NFW_CP_DATA
	} nfw_cp_state_t;

	typedef enum logic [1:0] {
		NFW_SR_IDLE,
		NFW_SR_ARMED,
		NFW_SR_WAIT
	} nfw_sr_state_t;

endpackage : nfw_pkg

// ===== src/nfw_cmd_port.sv
// Command byte decoder: register accesses and direct commands.
`timescale 1ns/1ps
module nfw_cmd_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_act,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output nfw_pkg::nfw_acc_t acc,
	output logic dcmd_valid,
	output logic [4:0] dcmd_code
);
	import nfw_pkg::*;
	`include "nfw_cfg.svh"

	nfw_cp_state_t state_ff;
	nfw_cp_state_t nxt_state;
	nfw_acc_t acc_ff;
	nfw_acc_t nxt_acc;
	logic dcmd_valid_ff;
	logic [4:0] dcmd_code_ff;
	logic [4:0] addr_ff;

	wire take = frame_act && rx_valid;
	wire is_cmd = rx_byte[`NFW_HDR_CMD_BIT];
	wire is_read = rx_byte[`NFW_HDR_READ_BIT];
	wire in_hdr = (state_ff == NFW_CP_HDR);

	// A dropped frame always returns to the header state, so a torn write is lost.
	always_comb begin
		nxt_state = state_ff;
		nxt_acc = '0;
		nxt_acc.addr = addr_ff;
		if (!frame_act) begin
			nxt_state = NFW_CP_HDR;
		end else if (take) begin
			unique case (state_ff)
				NFW_CP_HDR: begin
					nxt_acc.addr = rx_byte[4:0];
					nxt_acc.rd = !is_cmd && is_read;
					if (!is_cmd && !is_read) begin
						nxt_state = NFW_CP_DATA;
					end
				end
				NFW_CP_DATA: begin
					nxt_acc.wr = 1'b1;
					nxt_acc.data = rx_byte;
					nxt_state = NFW_CP_HDR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= NFW_CP_HDR;
			acc_ff <= '0;
			addr_ff <= 5'h00;
			dcmd_valid_ff <= 1'b0;
			dcmd_code_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			acc_ff <= nxt_acc;
			addr_ff <= nxt_acc.addr;
			dcmd_valid_ff <= take && in_hdr && is_cmd;
			dcmd_code_ff <= (take && in_hdr && is_cmd) ? rx_byte[4:0] : dcmd_code_ff;
		end
	end

	assign acc = acc_ff;
	assign dcmd_valid = dcmd_valid_ff;
	assign dcmd_code = dcmd_code_ff;

endmodule : nfw_cmd_port

// ===== src/nfw_wake_det.sv
// Always-on RF level comparator against the programmed wake threshold.
`timescale 1ns/1ps
module nfw_wake_det (
	input wire logic clk,
	input wire logic rst_n,
	input nfw_pkg::nfw_twl_t cfg,
	input wire logic [10:0] rf_level_mv,
	output logic detect_active,
	output logic above
);
	import nfw_pkg::*;
	`include "nfw_cfg.svh"

	// The extended range moves every code from 1 to 7 to a higher level.
	function automatic logic [10:0] thr_mv(input logic ext, input logic [2:0] code);
		logic [10:0] v;
		v = 11'd0;
		unique case (code)
			3'h1: v = ext ? `NFW_THR_E1 : `NFW_THR_N1;
			3'h2: v = ext ? `NFW_THR_E2 : `NFW_THR_N2;
			3'h3: v = ext ? `NFW_THR_E3 : `NFW_THR_N3;
			3'h4: v = ext ? `NFW_THR_E4 : `NFW_THR_N4;
			3'h5: v = ext ? `NFW_THR_E5 : `NFW_THR_N5;
			3'h6: v = ext ? `NFW_THR_E6 : `NFW_THR_N6;
			3'h7: v = ext ? `NFW_THR_E7 : `NFW_THR_N7;
			3'h0: v = 11'd0;
		endcase
		return v;
	endfunction : thr_mv

	logic above_ff;
	wire enabled = (cfg.wake_threshold != 3'h0);
	wire [10:0] level = thr_mv(cfg.extended_range_select, cfg.wake_threshold);
	wire nxt_above = enabled && (rf_level_mv > level);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			above_ff <= 1'b0;
		end else begin
			above_ff <= nxt_above;
		end
	end

	assign detect_active = enabled;
	assign above = above_ff;

endmodule : nfw_wake_det

// ===== src/nfw_top.sv
// Initialization, soft reset and RF wake-up control of the transceiver.
`timescale 1ns/1ps
`include "nfw_cfg.svh"
module nfw_top #(
	parameter int SOFT_RST_CYCLES = `NFW_SOFT_RST_WAIT_US * `NFW_CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic supply_hold_enable,
	input wire logic ss_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [10:0] rf_level_mv,
	input wire logic sel_req_valid,
	input wire logic [7:0] sel_req_byte,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic init_busy,
	output logic fifo_clear,
	output logic supply_on,
	output logic power_down,
	output logic internal_enable,
	output logic rf_detect_active,
	output logic wake_comparator_status,
	output logic [7:0] mod_clk_cfg,
	output logic [7:0] reg_io_cfg,
	output nfw_pkg::nfw_twl_t target_wake_level,
	output logic sdd_start,
	output logic [1:0] sdd_ident_size,
	output logic fifo_wr_valid,
	output logic [7:0] fifo_wr_data
);
	import nfw_pkg::*;

	// ------------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic [13:0] pin_meta_ff;
	logic [13:0] pin_sync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	wire rst_i_n = rst_sync_ff[1];

	// The level bus comes from a slow analog measurement, so a sample that tears
	// across an update only delays the comparator by one cycle.
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pin_meta_ff <= 14'h0004;
			pin_sync_ff <= 14'h0004;
		end else begin
			pin_meta_ff <= {rf_level_mv, ss_n, supply_hold_enable, en};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	wire en_s = pin_sync_ff[0];
	wire hold_s = pin_sync_ff[1];
	wire frame_act = !pin_sync_ff[2];
	wire [10:0] level_s = pin_sync_ff[13:3];

	// ------------------------------------------------------------------------
	// Command port and wake comparator
	// ------------------------------------------------------------------------
	nfw_acc_t acc;
	logic dcmd_valid;
	logic [4:0] dcmd_code;
	logic wake_above;
	logic detect_act;

	nfw_cmd_port u_cmd (
		.clk(clk),
		.rst_n(rst_i_n),
		.frame_act(frame_act),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.acc(acc),
		.dcmd_valid(dcmd_valid),
		.dcmd_code(dcmd_code)
	);

	nfw_twl_t twl_ff;

	nfw_wake_det u_wake (
		.clk(clk),
		.rst_n(rst_i_n),
		.cfg(twl_ff),
		.rf_level_mv(level_s),
		.detect_active(detect_act),
		.above(wake_above)
	);

	// ------------------------------------------------------------------------
	// Power control
	// ------------------------------------------------------------------------
	logic wake_ff;

	// The forced enable holds until the host confirms with its own enable;
	// a new wake event in the confirming cycle wins over the clear.
	wire nxt_wake = wake_above || (wake_ff && !en_s);
	wire int_en = en_s || wake_ff;
	wire pd = !int_en && !hold_s;

	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= nxt_wake;
		end
	end

	// ------------------------------------------------------------------------
	// Soft reset sequence
	// ------------------------------------------------------------------------
	nfw_sr_state_t sr_ff;
	nfw_sr_state_t nxt_sr;
	logic [15:0] wait_ff;

	wire dc_init = dcmd_valid && (dcmd_code == `NFW_DC_SOFT_INIT);
	wire dc_idle = dcmd_valid && (dcmd_code == `NFW_DC_IDLE);
	wire busy = (sr_ff == NFW_SR_WAIT);
	wire restore = (sr_ff == NFW_SR_ARMED) && dc_idle;
	wire wait_done = busy && (wait_ff == 16'(SOFT_RST_CYCLES - 1));

	// Commands arriving during the wait are dropped rather than queued.
	always_comb begin
		nxt_sr = sr_ff;
		unique case (sr_ff)
			NFW_SR_IDLE: begin
				if (dc_init) begin
					nxt_sr = NFW_SR_ARMED;
				end
			end
			NFW_SR_ARMED: begin
				if (restore) begin
					nxt_sr = NFW_SR_WAIT;
				end else if (dcmd_valid && !dc_init) begin
					nxt_sr = NFW_SR_IDLE;
				end
			end
			NFW_SR_WAIT: begin
				if (wait_done) begin
					nxt_sr = NFW_SR_IDLE;
				end
			end
			default: begin
				nxt_sr = NFW_SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			sr_ff <= NFW_SR_IDLE;
			wait_ff <= 16'h0000;
		end else begin
			sr_ff <= nxt_sr;
			wait_ff <= busy ? wait_ff + 16'h0001 : 16'h0000;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [7:0] mod_ff;
	logic [7:0] rio_ff;
	logic rd_valid_ff;
	logic [7:0] rd_data_ff;
	logic fifo_clear_ff;

	wire acc_ok = !busy;
	wire wr_mod = acc.wr && acc_ok && (acc.addr == `NFW_OFS_MOD_CLK);
	wire wr_rio = acc.wr && acc_ok && (acc.addr == `NFW_OFS_REG_IO);
	wire wr_twl = acc.wr && acc_ok && (acc.addr == `NFW_OFS_TWL);

	// Supply-domain registers lose their contents in power down.
	wire [7:0] nxt_mod = (pd || restore) ? `NFW_RST_MOD_CLK : wr_mod ? acc.data : mod_ff;
	wire [7:0] nxt_rio = (pd || restore) ? `NFW_RST_REG_IO : wr_rio ? acc.data : rio_ff;
	// The wake level sits on the always-on supply and ignores power down.
	wire [7:0] nxt_twl = restore ? `NFW_RST_TWL : wr_twl ? acc.data : twl_ff;

	wire [7:0] tprot = {wake_above, 7'h00};
	wire [7:0] rd_mux = (acc.addr == `NFW_OFS_MOD_CLK) ? mod_ff :
		(acc.addr == `NFW_OFS_REG_IO) ? rio_ff :
		(acc.addr == `NFW_OFS_TWL) ? twl_ff :
		(acc.addr == `NFW_OFS_TPROT) ? tprot : 8'h00;

	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			mod_ff <= `NFW_RST_MOD_CLK;
			rio_ff <= `NFW_RST_REG_IO;
			twl_ff <= `NFW_RST_TWL;
			rd_valid_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			fifo_clear_ff <= 1'b0;
		end else begin
			mod_ff <= nxt_mod;
			rio_ff <= nxt_rio;
			twl_ff <= nxt_twl;
			rd_valid_ff <= acc.rd && acc_ok;
			rd_data_ff <= (acc.rd && acc_ok) ? rd_mux : rd_data_ff;
			fifo_clear_ff <= dcmd_valid && acc_ok && (dcmd_code == `NFW_DC_FIFO_RST);
		end
	end

	// ------------------------------------------------------------------------
	// Selection request routing
	// ------------------------------------------------------------------------
	logic sdd_start_ff;
	logic fifo_wr_valid_ff;
	logic [7:0] fifo_wr_data_ff;

	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			sdd_start_ff <= 1'b0;
			fifo_wr_valid_ff <= 1'b0;
			fifo_wr_data_ff <= 8'h00;
		end else begin
			sdd_start_ff <= sel_req_valid && twl_ff.sdd_en;
			fifo_wr_valid_ff <= sel_req_valid && !twl_ff.sdd_en;
			fifo_wr_data_ff <= sel_req_valid ? sel_req_byte : fifo_wr_data_ff;
		end
	end

	assign rd_valid = rd_valid_ff;
	assign rd_data = rd_data_ff;
	assign init_busy = busy;
	assign fifo_clear = fifo_clear_ff;
	assign supply_on = !pd;
	assign power_down = pd;
	assign internal_enable = int_en;
	assign rf_detect_active = detect_act;
	assign wake_comparator_status = wake_above;
	assign mod_clk_cfg = mod_ff;
	assign reg_io_cfg = rio_ff;
	assign target_wake_level = twl_ff;
	assign sdd_start = sdd_start_ff;
	assign sdd_ident_size = {twl_ff.ident_size_hi, twl_ff.ident_size_lo};
	assign fifo_wr_valid = fifo_wr_valid_ff;
	assign fifo_wr_data = fifo_wr_data_ff;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_i_n);

	hold_keeps_supply_a: assert property (hold_s |-> supply_on)
		else $error("supply dropped while hold enable high");
	full_power_down_a: assert property (!en_s && !hold_s && !wake_ff |-> power_down)
		else $error("no power down with both enables low");
	zero_thr_off_a: assert property (twl_ff.wake_threshold == 3'h0 |=> !wake_above)
		else $error("comparator active with zero threshold");
	wake_forces_en_a: assert property (wake_above |=> internal_enable)
		else $error("wake event did not force enable");
	soft_restore_a: assert property (restore |=> (mod_clk_cfg == `NFW_RST_MOD_CLK
		&& target_wake_level == `NFW_RST_TWL) ##0 init_busy[*8])
		else $error("soft reset did not restore registers");
	twl_retain_a: assert property (power_down && !wr_twl && !restore
		|=> $stable(target_wake_level))
		else $error("wake level lost in power down");
	sdd_route_a: assert property (sel_req_valid && twl_ff.sdd_en
		|=> sdd_start && !fifo_wr_valid)
		else $error("selection request not taken by automatic detection");
	fifo_route_a: assert property (sel_req_valid && !twl_ff.sdd_en
		|=> fifo_wr_valid && fifo_wr_data == $past(sel_req_byte))
		else $error("selection request not passed to FIFO");
	status_read_a: assert property (acc.rd && acc_ok && acc.addr == `NFW_OFS_TPROT
		|=> rd_valid && rd_data[`NFW_TPROT_WAKE_BIT] == $past(wake_above))
		else $error("status read missed comparator bit");
	rio_readback_a: assert property (wr_rio && !pd |=> reg_io_cfg == $past(acc.data))
		else $error("regulator register write lost");

	wake_seen_c: cover property (power_down ##1 wake_above ##1 internal_enable);
	soft_seq_c: cover property (init_busy ##1 !init_busy);
	sdd_seen_c: cover property (sdd_start);
	fifo_clr_c: cover property (fifo_clear);

endmodule : nfw_top

// ===== verif/nfw_host_model.sv
// Host controller model: enable pins, slave select and the command byte port.
`timescale 1ns/1ps
module nfw_host_model (
	input wire logic clk,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic en,
	output logic supply_hold_enable,
	output logic ss_n,
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	initial begin
		en = 1'b0;
		supply_hold_enable = 1'b0;
		ss_n = 1'b1;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// ------------------------------------------------------------------------
	// Pins and bytes
	// ------------------------------------------------------------------------
	// Each pin gets several edges so the synchronisers see the order we meant.
	task automatic power_up();
		tick(1);
		en = 1'b1;
		tick(3);
		supply_hold_enable = 1'b1;
		tick(3);
		ss_n = 1'b0;
		tick(4);
	endtask : power_up

	task automatic set_select(input logic s);
		tick(1);
		ss_n = s;
	endtask : set_select

	task automatic set_power(input logic e, input logic h);
		tick(1);
		en = e;
		supply_hold_enable = h;
	endtask : set_power

	// The byte line shows the inverse once released, so a stale value never matches.
	task automatic send(input logic [7:0] b);
		tick(1);
		rx_valid = 1'b1;
		rx_byte = b;
		tick(1);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask : send

	task automatic dcmd(input logic [4:0] c);
		send({3'b100, c});
	endtask : dcmd

	task automatic write(input logic [4:0] a, input logic [7:0] d);
		send({3'b000, a});
		send(d);
	endtask : write

	task automatic read(input logic [4:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		send({3'b010, a});
		for (int i = 0; i < 4 && !ok; i++) begin
			tick(1);
			if (rd_valid === 1'b1) begin
				d = rd_data;
				ok = 1'b1;
			end
		end
	endtask : read

	// ------------------------------------------------------------------------
	// Initialization sequence
	// ------------------------------------------------------------------------
	task automatic init(input logic [7:0] mc, input logic [7:0] io, input logic do_io,
		input int wait_cycles);
		dcmd(5'h03);
		dcmd(5'h00);
		tick(wait_cycles);
		dcmd(5'h0f);
		write(5'h09, mc);
		if (do_io) begin
			write(5'h0b, io);
		end
		write(5'h18, 8'h00);
	endtask : init
endmodule : nfw_host_model

// ===== verif/nfc_init_and_target_wakeup_test.sv
// Self-checking testbench of the initialization and RF wake-up block.
`timescale 1ns/1ps
`include "nfw_cfg.svh"
module nfc_init_and_target_wakeup_test;
	import nfw_pkg::*;
	localparam int SRC = 20;
	logic clk, rst_n, en, supply_hold_enable, ss_n, rx_valid, sel_req_valid;
	logic [7:0] rx_byte, sel_req_byte, rd_data, mod_clk_cfg, reg_io_cfg, fifo_wr_data, d, v;
	logic [10:0] rf_level_mv, t;
	logic rd_valid, init_busy, fifo_clear, supply_on, power_down, internal_enable;
	logic rf_detect_active, wake_comparator_status, sdd_start, fifo_wr_valid, ok;
	logic [1:0] sdd_ident_size;
	nfw_twl_t target_wake_level, twl;
	int mismatches = 0;
	int cmp_count = 0;
	int fifo_cnt = 0;
	int busy_cnt = 0;

	nfw_top #(.SOFT_RST_CYCLES(SRC)) i_dut (.clk(clk), .rst_n(rst_n), .en(en),
		.supply_hold_enable(supply_hold_enable), .ss_n(ss_n), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rf_level_mv(rf_level_mv), .sel_req_valid(sel_req_valid),
		.sel_req_byte(sel_req_byte), .rd_valid(rd_valid), .rd_data(rd_data),
		.init_busy(init_busy), .fifo_clear(fifo_clear), .supply_on(supply_on),
		.power_down(power_down), .internal_enable(internal_enable),
		.rf_detect_active(rf_detect_active), .wake_comparator_status(wake_comparator_status),
		.mod_clk_cfg(mod_clk_cfg), .reg_io_cfg(reg_io_cfg),
		.target_wake_level(target_wake_level), .sdd_start(sdd_start),
		.sdd_ident_size(sdd_ident_size), .fifo_wr_valid(fifo_wr_valid),
		.fifo_wr_data(fifo_wr_data));

	nfw_host_model i_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .en(en),
		.supply_hold_enable(supply_hold_enable), .ss_n(ss_n), .rx_valid(rx_valid),
		.rx_byte(rx_byte));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (fifo_clear === 1'b1) fifo_cnt++;
		if (init_busy === 1'b1) busy_cnt++;
	end

	// ------------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------------
	function automatic logic [10:0] thr(input logic ext, input logic [2:0] c);
		case ({ext, c})
			4'h1: return `NFW_THR_N1;
			4'h2: return `NFW_THR_N2;
			4'h3: return `NFW_THR_N3;
			4'h4: return `NFW_THR_N4;
			4'h5: return `NFW_THR_N5;
			4'h6: return `NFW_THR_N6;
			4'h7: return `NFW_THR_N7;
			4'h9: return `NFW_THR_E1;
			4'ha: return `NFW_THR_E2;
			4'hb: return `NFW_THR_E3;
			4'hc: return `NFW_THR_E4;
			4'hd: return `NFW_THR_E5;
			4'he: return `NFW_THR_E6;
			default: return `NFW_THR_E7;
		endcase
	endfunction : thr

	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		summarize();
	end

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		void'($urandom(32'h3067));
		rst_n = 1'b0;
		rf_level_mv = 11'h000;
		sel_req_valid = 1'b0;
		sel_req_byte = 8'h00;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("power_down", 1, power_down);
		chk("target_wake_level", `NFW_RST_TWL, target_wake_level);
		i_host.power_up();
		// Soft reset must undo earlier writes and refuse writes while it runs.
		v = 8'($urandom) | 8'h01;
		i_host.write(`NFW_OFS_MOD_CLK, v);
		i_host.write(`NFW_OFS_TWL, v);
		i_host.tick(3);
		chk("mod_clk_cfg", v, mod_clk_cfg);
		busy_cnt = 0;
		i_host.dcmd(`NFW_DC_SOFT_INIT);
		i_host.dcmd(`NFW_DC_IDLE);
		i_host.tick(3);
		chk("init_busy", 1, init_busy);
		chk("mod_clk_cfg", `NFW_RST_MOD_CLK, mod_clk_cfg);
		chk("target_wake_level", `NFW_RST_TWL, target_wake_level);
		i_host.write(`NFW_OFS_REG_IO, 8'ha5);
		for (int i = 0; i < 60 && init_busy === 1'b1; i++) i_host.tick(1);
		chk("init_busy", 0, init_busy);
		chk("busy_cycles", SRC, busy_cnt);
		chk("reg_io_cfg", `NFW_RST_REG_IO, reg_io_cfg);
		// Full host initialization, optional regulator write drawn at random.
		v = 8'($urandom);
		d = 8'($urandom);
		ok = 1'($urandom);
		fifo_cnt = 0;
		i_host.init(v, d, ok, SRC + 2);
		i_host.tick(3);
		chk("fifo_clear_count", 1, fifo_cnt);
		chk("mod_clk_cfg", v, mod_clk_cfg);
		chk("reg_io_cfg", ok ? d : `NFW_RST_REG_IO, reg_io_cfg);
		chk("target_wake_level", 8'h00, target_wake_level);
		chk("rf_detect_active", 0, rf_detect_active);
		i_host.read(`NFW_OFS_MOD_CLK, d, ok);
		chk("read_mod_clk", {3'h0, 1'b1, v}, {3'h0, ok, d});
		i_host.read(5'h1f, d, ok);
		chk("read_unmapped", 9'h100, {ok, d});
		// A frame dropped between header and data must lose the write.
		i_host.send({3'b000, `NFW_OFS_MOD_CLK});
		i_host.set_select(1'b1);
		i_host.tick(3);
		i_host.set_select(1'b0);
		i_host.tick(3);
		i_host.send({2'b01, ~v[5:0]});
		i_host.tick(3);
		chk("mod_clk_cfg", v, mod_clk_cfg);
		// Codes 1 to 7 in both ranges at the level and just above it, code 0 in the extended range only at full scale.
		for (int k = 1; k < 16; k++) begin
			twl = 8'({k[3], k[2:0]});
			t = k[2:0] == 3'h0 ? 11'h7ff : thr(k[3], k[2:0]);
			rf_level_mv = k[2:0] == 3'h0 ? 11'h7ff : t;
			i_host.write(`NFW_OFS_TWL, twl);
			i_host.tick(6);
			chk("wake_comparator_status", 0, wake_comparator_status);
			chk("rf_detect_active", k[2:0] != 3'h0, rf_detect_active);
			if (k[2:0] != 3'h0) begin
				rf_level_mv = t + 11'h001;
				i_host.tick(6);
				chk("wake_comparator_status", 1, wake_comparator_status);
				i_host.read(`NFW_OFS_TPROT, d, ok);
				chk("tprot_wake_bit", 2'h3, {ok, d[`NFW_TPROT_WAKE_BIT]});
			end
		end
		// Power down with the wake register kept, then an RF wake-up.
		twl = {2'($urandom), 3'h0, 3'h1};
		rf_level_mv = 11'h000;
		i_host.write(`NFW_OFS_TWL, twl);
		ok = 1'($urandom);
		i_host.set_power(ok, 1'b1);
		i_host.tick(4);
		chk("supply_on", 1, supply_on);
		chk("internal_enable", ok, internal_enable);
		i_host.set_power(1'b0, 1'b0);
		i_host.tick(4);
		chk("power_down", 1, power_down);
		chk("internal_enable", 0, internal_enable);
		chk("target_wake_level", twl, target_wake_level);
		rf_level_mv = thr(1'b0, 3'h1) + 11'h001;
		i_host.tick(6);
		chk("internal_enable", 1, internal_enable);
		chk("power_down", 0, power_down);
		i_host.set_power(1'b1, 1'b1);
		rf_level_mv = 11'h000;
		i_host.tick(4);
		// Selection requests with automatic detection on and off.
		for (int s = 0; s < 2; s++) begin
			twl = {2'($urandom), 1'(s), 5'h00};
			i_host.write(`NFW_OFS_TWL, twl);
			i_host.tick(3);
			v = 8'($urandom);
			sel_req_valid = 1'b1;
			sel_req_byte = v;
			i_host.tick(1);
			chk("sdd_start", s, sdd_start);
			chk("fifo_wr_valid", !s, fifo_wr_valid);
			if (s == 0) chk("fifo_wr_data", v, fifo_wr_data);
			chk("sdd_ident_size", twl[7:6], sdd_ident_size);
			sel_req_valid = 1'b0;
			sel_req_byte = ~v;
		end
		summarize();
	end
endmodule : nfc_init_and_target_wakeup_test
